// File: core/bwio_pkg.sv
package bwio_pkg;
  // ==========================================================
  // Register offsets within one port
  localparam logic [1:0] BWIO_OFS_VALUE = 2'h0;
  localparam logic [1:0] BWIO_OFS_DIR = 2'h1;
  localparam logic [1:0] BWIO_OFS_OPT = 2'h2;
  // ==========================================================
  // Reset values
  localparam logic [7:0] BWIO_RST_VALUE = 8'h00;
  localparam logic [7:0] BWIO_RST_DIR = 8'h00;
  localparam logic [7:0] BWIO_RST_OPT = 8'h00;
  localparam logic [7:0] BWIO_RST_ZERO = 8'h00;
  // ==========================================================
  // Trigger selection for line interrupts
  localparam logic [1:0] BWIO_TRIG_FALL = 2'h0;
  localparam logic [1:0] BWIO_TRIG_RISE = 2'h1;
  localparam logic [1:0] BWIO_TRIG_LOW = 2'h2;
  // Line mode decode
  typedef enum logic [2:0] {
    BWIO_IN_PULLUP,
    BWIO_IN_FLOAT,
    BWIO_IN_IRQ,
    BWIO_IN_ANALOG,
    BWIO_OUT_OD,
    BWIO_OUT_PP
  } bwio_mode_e;
endpackage

// File: core/bwio_sync.sv
`timescale 1ns/1ps
// ==========================================================
// Two-flop synchroniser for the pin levels
module bwio_sync
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Data
  input wire logic [7:0] i_async,
  output logic [7:0] o_sync
);
  logic [7:0] meta_reg;
  logic [7:0] meta_next;
  logic [7:0] sync_reg;
  logic [7:0] sync_next;

  // Next values, first stage only feeds the second
  always_comb
  begin
    meta_next = i_async;
    sync_next = meta_reg;
  end

  // Registers
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      meta_reg <= bwio_pkg::BWIO_RST_ZERO;
      sync_reg <= bwio_pkg::BWIO_RST_ZERO;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign o_sync = sync_reg;
endmodule

// File: core/bwio_irq.sv
`timescale 1ns/1ps
// ==========================================================
// Line interrupt request combiner
module bwio_irq
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Line state
  input wire logic [7:0] i_level,
  input wire logic [7:0] i_enable,
  input wire logic [1:0] i_trig,
  // Request
  output logic o_req
);
  logic [7:0] prev_reg;
  logic [7:0] prev_next;
  logic req_reg;
  logic req_next;

  // Per-line trigger, qualified by the enable of the line
  always_comb
  begin
    prev_next = i_level;
    case (i_trig)
      bwio_pkg::BWIO_TRIG_RISE: req_next = |(i_enable & i_level & ~prev_reg);
      bwio_pkg::BWIO_TRIG_LOW: req_next = |(i_enable & ~i_level);
      default: req_next = |(i_enable & ~i_level & prev_reg);
    endcase
  end

  // Registers
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      prev_reg <= bwio_pkg::BWIO_RST_ZERO;
      req_reg <= 1'b0;
    end
    else
    begin
      prev_reg <= prev_next;
      req_reg <= req_next;
    end
  end

  assign o_req = req_reg;
endmodule

// File: core/bwio_port.sv
`timescale 1ns/1ps
// ==========================================================
// Summary of operation
// - Three 8-bit registers, bit n for line n
// - Dir0 opt0 val0: input with pull-up
// - Dir0 opt0 val1: floating input, no pull-up
// - Dir0 opt1 val0: pull-up input feeding interrupts
// - Dir0 opt1 val1: analog input to converter
// - Dir1 opt0: open-drain output
// - Dir1 opt1: push-pull output of latch
// - Input lines read back pin level
// - Writes always update value latch
// - Reset clears all three registers
// - Direction and option registers read and written like RAM
// - Falling, rising or low-level trigger per port
// - Line requests feed shared edge source
module bwio_port
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Register port
  input wire logic i_sel,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // Interrupt configuration
  input wire logic [1:0] i_trig,
  input wire logic i_edge_polarity_bit,
  output logic o_line_irq,
  // Pins
  input wire logic [7:0] i_pin,
  output logic [7:0] o_pin_out,
  output logic [7:0] o_pin_oe,
  output logic [7:0] o_pullup_en,
  output logic [7:0] o_analog_sel,
  output logic [7:0] o_heavy_sink_en
);
  // ==========================================================
  // Register state
  // Port registers, reached from the register port
  logic [7:0] line_value_latch_reg;
  logic [7:0] line_value_latch_next;

  logic [7:0] line_direction_select_reg;
  logic [7:0] line_direction_select_next;

  logic [7:0] line_option_select_reg;
  logic [7:0] line_option_select_next;

  // Read data, held until the next read
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Pin drive, registered so the pads see no decode glitches
  logic [7:0] pin_out_reg;
  logic [7:0] pin_out_next;

  logic [7:0] pin_oe_reg;
  logic [7:0] pin_oe_next;

  // Pad options
  logic [7:0] pullup_reg;
  logic [7:0] pullup_next;

  logic [7:0] analog_reg;
  logic [7:0] analog_next;

  logic [7:0] heavy_reg;
  logic [7:0] heavy_next;

  // Interrupt path
  logic [7:0] irq_en_reg;
  logic [7:0] irq_en_next;

  logic src_prev_reg;
  logic src_prev_next;

  logic irq_out_reg;
  logic irq_out_next;

  // Synchronised pins and combined line request
  logic [7:0] pin_sync;
  logic line_req;

  // Decode of one line's mode from its three bits
  function automatic bwio_pkg::bwio_mode_e line_mode(input logic d, input logic o,
                                                     input logic v);
    if (d)
      line_mode = o ? bwio_pkg::BWIO_OUT_PP : bwio_pkg::BWIO_OUT_OD;
    else if (o)
      line_mode = v ? bwio_pkg::BWIO_IN_ANALOG : bwio_pkg::BWIO_IN_IRQ;
    else
      line_mode = v ? bwio_pkg::BWIO_IN_FLOAT : bwio_pkg::BWIO_IN_PULLUP;
  endfunction

  // Value register read-back: stored bit for outputs, pin for inputs
  // An input line never returns its latch, which is why bit updates on
  // a mixed port rewrite the input options by accident
  function automatic logic [7:0] value_readback(input logic [7:0] dir,
                                                input logic [7:0] latch,
                                                input logic [7:0] pins);
    value_readback = (dir & latch) | (~dir & pins);
  endfunction

  // ==========================================================
  // Pin sampling and interrupt request
  // Pins are asynchronous; two flops before any logic reads them
  bwio_sync u_sync
  (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_pin),
    .o_sync(pin_sync)
  );

  bwio_irq u_irq
  (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_level(pin_sync),
    .i_enable(irq_en_reg),
    .i_trig(i_trig),
    .o_req(line_req)
  );

  // ==========================================================
  // Register writes; no side effects, plain RAM-like storage
  // Write and read in one cycle: the read returns the old value
  always_comb
  begin
    line_value_latch_next = line_value_latch_reg;
    line_direction_select_next = line_direction_select_reg;
    line_option_select_next = line_option_select_reg;
    if (i_sel && i_wr)
    begin
      // Index 3 is unmapped; its writes are dropped
      case (i_addr)
        bwio_pkg::BWIO_OFS_VALUE:
        begin
          line_value_latch_next = i_wdata;
        end
        bwio_pkg::BWIO_OFS_DIR:
        begin
          line_direction_select_next = i_wdata;
        end
        bwio_pkg::BWIO_OFS_OPT:
        begin
          line_option_select_next = i_wdata;
        end
        default: ;
      endcase
    end
  end

  // Read data: pins for input lines, stored bits otherwise
  always_comb
  begin
    rdata_next = rdata_reg;
    if (i_sel && i_rd)
    begin
      case (i_addr)
        bwio_pkg::BWIO_OFS_VALUE:
        begin
          rdata_next = value_readback(line_direction_select_reg, line_value_latch_reg,
                                      pin_sync);
        end
        bwio_pkg::BWIO_OFS_DIR:
        begin
          rdata_next = line_direction_select_reg;
        end
        bwio_pkg::BWIO_OFS_OPT:
        begin
          rdata_next = line_option_select_reg;
        end
        default: rdata_next = bwio_pkg::BWIO_RST_ZERO;
      endcase
    end
  end

  // ==========================================================
  // Pin drive from the decoded mode of each line
  // Mode decode is registered, so pads follow a write one cycle later
  always_comb
  begin
    pin_out_next = bwio_pkg::BWIO_RST_ZERO;
    pin_oe_next = bwio_pkg::BWIO_RST_ZERO;
    pullup_next = bwio_pkg::BWIO_RST_ZERO;
    analog_next = bwio_pkg::BWIO_RST_ZERO;
    heavy_next = bwio_pkg::BWIO_RST_ZERO;
    irq_en_next = bwio_pkg::BWIO_RST_ZERO;
    for (int n = 0; n < 8; n++)
    begin
      case (line_mode(line_direction_select_reg[n], line_option_select_reg[n],
                      line_value_latch_reg[n]))
        bwio_pkg::BWIO_IN_PULLUP:
        begin
          pullup_next[n] = 1'b1;
        end
        bwio_pkg::BWIO_IN_FLOAT:
        begin
          pullup_next[n] = 1'b0;
        end
        bwio_pkg::BWIO_IN_IRQ:
        begin
          pullup_next[n] = 1'b1;
          irq_en_next[n] = 1'b1;
        end
        bwio_pkg::BWIO_IN_ANALOG:
        begin
          // No pull-up and no drive, else the converter sees a load
          analog_next[n] = 1'b1;
        end
        bwio_pkg::BWIO_OUT_OD:
        begin
          // Drive low only; a high latch releases the pin
          pin_oe_next[n] = ~line_value_latch_reg[n];
          heavy_next[n] = 1'b1;
        end
        bwio_pkg::BWIO_OUT_PP:
        begin
          // Both levels driven; heavy sink allowed here too
          pin_out_next[n] = line_value_latch_reg[n];
          pin_oe_next[n] = 1'b1;
          heavy_next[n] = 1'b1;
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Shared source request: edge of the combined line request
  // Only an edge is passed on; a level trigger that stays low raises
  // one request, matching the edge-only shared source
  always_comb
  begin
    // Edge taken from the registered request, never from the pins
    src_prev_next = line_req;
    if (i_edge_polarity_bit)
      irq_out_next = line_req & ~src_prev_reg;
    else
      irq_out_next = ~line_req & src_prev_reg;
  end

  // ==========================================================
  // Registers; reset leaves every line a pull-up input
  // Synchronous reset; every register runs on every edge
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      // Port registers
      line_value_latch_reg <= bwio_pkg::BWIO_RST_VALUE;
      line_direction_select_reg <= bwio_pkg::BWIO_RST_DIR;
      line_option_select_reg <= bwio_pkg::BWIO_RST_OPT;
      // Read data
      rdata_reg <= bwio_pkg::BWIO_RST_ZERO;
      // Pad drive and options
      pin_out_reg <= bwio_pkg::BWIO_RST_ZERO;
      pin_oe_reg <= bwio_pkg::BWIO_RST_ZERO;
      pullup_reg <= bwio_pkg::BWIO_RST_ZERO;
      analog_reg <= bwio_pkg::BWIO_RST_ZERO;
      heavy_reg <= bwio_pkg::BWIO_RST_ZERO;
      // Interrupt path
      irq_en_reg <= bwio_pkg::BWIO_RST_ZERO;
      src_prev_reg <= 1'b0;
      irq_out_reg <= 1'b0;
    end
    else
    begin
      // Port registers
      line_value_latch_reg <= line_value_latch_next;
      line_direction_select_reg <= line_direction_select_next;
      line_option_select_reg <= line_option_select_next;
      // Read data
      rdata_reg <= rdata_next;
      // Pad drive and options
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
      pullup_reg <= pullup_next;
      analog_reg <= analog_next;
      heavy_reg <= heavy_next;
      // Interrupt path
      irq_en_reg <= irq_en_next;
      src_prev_reg <= src_prev_next;
      irq_out_reg <= irq_out_next;
    end
  end

  // Outputs straight from flip-flops
  // Every output is a plain register copy, so pads never glitch
  assign o_rdata = rdata_reg;
  assign o_pin_out = pin_out_reg;
  assign o_pin_oe = pin_oe_reg;
  assign o_pullup_en = pullup_reg;
  assign o_analog_sel = analog_reg;
  assign o_heavy_sink_en = heavy_reg;
  assign o_line_irq = irq_out_reg;
endmodule

// File: tb/bwio_port_assertions.sv
`timescale 1ns/1ps
// ==========================================================
// Port behaviour checker
module bwio_chk
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Register port
  input wire logic i_sel,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  // Interrupt
  input wire logic [1:0] i_trig,
  input wire logic i_edge_polarity_bit,
  input wire logic o_line_irq,
  // Pins
  input wire logic [7:0] i_pin,
  input wire logic [7:0] o_pin_out,
  input wire logic [7:0] o_pin_oe,
  input wire logic [7:0] o_pullup_en,
  input wire logic [7:0] o_analog_sel,
  input wire logic [7:0] o_heavy_sink_en
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // ==========================================================
  // Access sequences
  sequence dir_wr;
    i_sel && i_wr && i_addr == 2'h1;
  endsequence
  // Config must be settled too, else the read sees a stale mode
  sequence quiet_in;
    ($stable(i_pin) && o_heavy_sink_en == 8'h00 && !i_wr)[*4];
  endsequence
  // ==========================================================
  // Properties
  reset_clear_a: assert property ($rose(i_rst_b) |->
    (o_pin_oe | o_heavy_sink_en | o_analog_sel) == 8'h00) else $error("outputs not cleared");
  dir_to_pins_a: assert property (dir_wr |=> ##1
    o_heavy_sink_en == $past(i_wdata, 2)) else $error("direction not applied");
  dir_readback_a: assert property (dir_wr ##1 (i_sel && i_rd && !i_wr && i_addr == 2'h1)
    |=> o_rdata == $past(i_wdata, 2)) else $error("direction readback wrong");
  unmapped_read_a: assert property (i_sel && i_rd && i_addr == 2'h3
    |=> o_rdata == 8'h00) else $error("unmapped read not zero");
  input_read_a: assert property (quiet_in ##0 (i_sel && i_rd && i_addr == 2'h0)
    |=> o_rdata == $past(i_pin)) else $error("input read not pin level");
  irq_pulse_a: assert property (o_line_irq |=> !o_line_irq)
    else $error("request pulse too long");
  analog_only_a: assert property ((o_analog_sel & (o_pin_oe | o_pullup_en)) == 8'h00)
    else $error("analog line also driven or pulled");
  output_nopull_a: assert property ((o_heavy_sink_en & (o_pullup_en | o_analog_sel)) == 8'h00)
    else $error("output line pulled or analog");
  input_undriven_a: assert property ((o_pin_oe & ~o_heavy_sink_en) == 8'h00)
    else $error("input line driven");
endmodule

bind bwio_port bwio_chk i_chk (.*);

// File: tb/bwio_pins.sv
`timescale 1ns/1ps
// ==========================================================
// Board side of the eight lines
module bwio_pins
(
  // Clock
  input wire logic i_clk,
  // Port drive
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe,
  input wire logic [7:0] i_pu,
  // Board drivers
  input wire logic [7:0] i_ext,
  input wire logic [7:0] i_ext_en,
  // Resolved level
  output logic [7:0] o_lvl
);
  logic [7:0] float_reg = 8'h55;
  // Undriven lines wander, so a stale value cannot pass as a read
  always_ff @(posedge i_clk)
  begin
    float_reg <= ~float_reg;
  end
  // Port drive wins, then board driver, then pull-up
  always_comb
  begin
    o_lvl = (i_oe & i_out) | (i_ext_en & ~i_oe & i_ext)
      | (i_pu & ~i_oe & ~i_ext_en) | (float_reg & ~(i_oe | i_ext_en | i_pu));
  end
endmodule

// File: tb/bwio_port_test.sv
`timescale 1ns/1ps
module bwio_port_test;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_sel = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [1:0] i_addr = 2'h0;
  logic [7:0] i_wdata = 8'h00;
  logic [1:0] i_trig = 2'h0;
  logic i_edge_polarity_bit = 1'b0;
  logic [7:0] ext = 8'h00;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] o_rdata, i_pin, o_pin_out, o_pin_oe, o_pullup_en, o_analog_sel, o_heavy_sink_en;
  logic o_line_irq;
  int fail_count = 0;
  int n_compared = 0;
  // ==========================================================
  // Design and board
  bwio_port i_dut (.*);
  bwio_pins i_pins (.i_clk(i_clk), .i_out(o_pin_out), .i_oe(o_pin_oe), .i_pu(o_pullup_en),
    .i_ext(ext), .i_ext_en(ext_en), .o_lvl(i_pin));
  initial
  begin
    forever #12.5 i_clk = ~i_clk;
  end
  // ==========================================================
  // Bus and compare tasks; strobes stay up until idle
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle();
    i_sel = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
  endtask
  // Whole bytes only, never bit updates of the latch
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    {i_sel, i_wr, i_rd, i_addr, i_wdata} = {3'b110, a, d};
    @(negedge i_clk);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    {i_sel, i_wr, i_rd, i_addr} = {3'b101, a};
    @(negedge i_clk);
    chk(o_rdata, exp);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    repeat (6) @(negedge i_clk);
    chk(o_pullup_en, 8'hFF);
    chk(o_pin_oe | o_analog_sel, 8'h00);
    rd(2'h0, 8'hFF);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h00);
  endtask
  task automatic t_regs();
    wr(2'h1, 8'h5A);
    rd(2'h1, 8'h5A);
    wr(2'h2, 8'hC3);
    wr(2'h3, 8'hFF);
    rd(2'h2, 8'hC3);
    rd(2'h3, 8'h00);
  endtask
  // One line per input mode, two per output mode, a single analog line at a time
  task automatic t_modes();
    ext_en = 8'h0F;
    ext = 8'h05;
    wr(2'h1, 8'hF0);
    wr(2'h2, 8'hCC);
    wr(2'h0, 8'hAA);
    idle();
    repeat (3) @(negedge i_clk);
    chk(o_pullup_en, 8'h05);
    chk(o_analog_sel, 8'h08);
    chk(o_pin_oe, 8'hD0);
    chk(o_pin_out, 8'h80);
    chk(o_heavy_sink_en, 8'hF0);
    rd(2'h0, 8'hA5);
    ext = 8'h0A;
    wr(2'h0, 8'h55);
    idle();
    repeat (3) @(negedge i_clk);
    chk(o_pullup_en, 8'h0A);
    chk(o_analog_sel, 8'h04);
    chk(o_pin_oe, 8'hE0);
    chk(o_pin_out, 8'h40);
    rd(2'h0, 8'h5A);
    chk(o_rdata & 8'h0F, 8'h0A);
  endtask
  task automatic irq_case(input logic [1:0] tr, input logic pol, input logic a,
    input logic b, input logic [7:0] exp);
    int n;
    n = 0;
    i_trig = tr;
    i_edge_polarity_bit = pol;
    ext[2] = a;
    repeat (8) @(negedge i_clk);
    ext[2] = b;
    repeat (12)
    begin
      @(negedge i_clk);
      n += (o_line_irq === 1'b1);
    end
    chk(8'(n), exp);
  endtask
  task automatic t_irq();
    wr(2'h1, 8'h00);
    wr(2'h2, 8'h04);
    wr(2'h0, 8'h00);
    idle();
    ext_en = 8'h04;
    irq_case(2'h0, 1'b1, 1'b1, 1'b0, 8'h01);
    irq_case(2'h1, 1'b1, 1'b0, 1'b1, 8'h01);
    irq_case(2'h1, 1'b1, 1'b1, 1'b0, 8'h00);
    irq_case(2'h2, 1'b1, 1'b1, 1'b0, 8'h01);
    irq_case(2'h2, 1'b0, 1'b0, 1'b1, 8'h01);
    wr(2'h2, 8'h00);
    idle();
    irq_case(2'h0, 1'b1, 1'b1, 1'b0, 8'h00);
  endtask
  // ==========================================================
  // Verdict, main sequence and watchdog
  task automatic summarize();
    if (fail_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge i_clk);
    i_rst_b = 1'b1;
    t_reset();
    t_regs();
    t_modes();
    t_irq();
    summarize();
  end
  initial
  begin
    repeat (3000) @(posedge i_clk);
    fail_count++;
    summarize();
  end
endmodule
